// ---- hw/utrd_pkg.sv ----
// Shared constants and types of the serial data path.
// Assumes a 32-bit AHB-Lite bus and one 10 MHz clock.
package utrd_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_CSA  = 8'h04;
   localparam logic [7:0] ADDR_CSB  = 8'h08;
   localparam logic [7:0] ADDR_CSC  = 8'h0c;
   // Status bits of ctrl_status_a
   localparam int RX_READY_POS = 7;
   localparam int TX_DONE_POS  = 6;
   localparam int TX_EMPTY_POS = 5;
   // Control bits of ctrl_status_b
   localparam int TX_DONE_IE_POS  = 6;
   localparam int TX_EMPTY_IE_POS = 5;
   localparam int RX_EN_POS       = 4;
   localparam int TX_EN_POS       = 3;
   localparam int RX_NINTH_POS    = 1;
   localparam int TX_NINTH_POS    = 0;
   // Frame format bits of the format register
   localparam int SYNC_POS   = 6;
   localparam int PAR_HI_POS = 5;
   localparam int PAR_LO_POS = 4;
   localparam int STOP2_POS  = 3;
   localparam int SIZE_POS   = 0;
   localparam logic [2:0] SIZE_NINE  = 3'h7;
   localparam logic [7:0] CSB_RESET  = 8'h00;
   localparam logic [7:0] CSC_RESET  = 8'h06;
   localparam logic [3:0] BITS_NINE  = 4'h9;
   localparam logic [3:0] BITS_BASE  = 4'h5;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_START  = 3'b001,
      ST_DATA   = 3'b010,
      ST_PARITY = 3'b011,
      ST_STOP   = 3'b100,
      ST_STOP2  = 3'b101,
      ST_FINISH = 3'b110
   } utrd_state_t;
endpackage

// ---- hw/utrd_rx_if.sv ----
// Link between the register block and the receiver.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface utrd_rx_if;
   logic       tick;
   logic       enable;
   logic       line;
   logic       parity_en;
   logic [3:0] nbits;
   logic       done;
   logic [8:0] data;
   modport rx  (input tick, enable, line, parity_en, nbits, output done, data);
   modport ctl (output tick, enable, line, parity_en, nbits, input done, data);
endinterface

// ---- hw/utrd_rx.sv ----
// Receive shift logic: start detect, data shift, stop.
// Assumes a filtered serial line and a one-cycle bit tick.
`timescale 1ns/1ps
module utrd_rx (
   input  wire logic hclk,
   input  wire logic hresetn,
   utrd_rx_if.rx     rxl
);
   utrd_pkg::utrd_state_t state;
   logic [3:0]            cnt;
   logic [8:0]            shreg;

   // Frame sequencer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= utrd_pkg::ST_IDLE;
         cnt   <= 4'h0;
         shreg <= 9'h000;
      end
      else if (!rxl.enable)
         state <= utrd_pkg::ST_IDLE;
      else if (rxl.tick)
      begin
         case (state)
            utrd_pkg::ST_IDLE:
            begin
               if (!rxl.line)                        // [RL13]
               begin
                  state <= utrd_pkg::ST_DATA;
                  cnt   <= 4'h0;
                  shreg <= 9'h000;                   // [RL16]
               end
            end
            utrd_pkg::ST_DATA:
            begin
               shreg[cnt] <= rxl.line;               // [RL13]
               cnt        <= cnt + 4'h1;
               if (cnt == rxl.nbits - 4'h1)
                  state <= rxl.parity_en ? utrd_pkg::ST_PARITY : utrd_pkg::ST_STOP;
            end
            utrd_pkg::ST_PARITY:
               state <= utrd_pkg::ST_STOP;
            // Back to idle at first stop; a second stop is not looked at
            utrd_pkg::ST_STOP:
               state <= utrd_pkg::ST_IDLE;          // [RL14]
            default:
               state <= utrd_pkg::ST_IDLE;
         endcase
      end
   end

   // Frame complete pulse and data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rxl.done <= 1'b0;
         rxl.data <= 9'h000;
      end
      else
      begin
         rxl.done <= rxl.enable && rxl.tick && state == utrd_pkg::ST_STOP;
         if (rxl.enable && rxl.tick && state == utrd_pkg::ST_STOP)
            rxl.data <= shreg;                       // [RL15]
      end
   end
endmodule

// ---- hw/utrd_top.sv ----
// Serial transmit/receive data path with AHB-Lite registers.
// Assumes a baud tick from a separate generator on hclk.
// Behaviour
// [RL1] Software sets ninth bit before low byte
// [RL2] Empty flag high exactly when buffer empty
// [RL3] Data write loads buffer, clears empty flag
// [RL4] Empty request level while enabled and empty
// [RL5] Done flag when frame out, buffer empty
// [RL6] Done cleared by service or write one
// [RL7] Done request raised when enabled and set
// [RL8] Parity bit between data and stop
// [RL9] Disable waits for shifter and buffer empty
// [RL10] Disabled transmitter releases the output pin
// [RL11] Receive enable takes over the input pin
// [RL12] Synchronous mode uses external transfer clock
// [RL13] Start bit begins frame, bits sampled per tick
// [RL14] Second stop bit is ignored
// [RL15] First stop moves frame into buffer
// [RL16] Unused upper read bits are zero
// [RL17] Software writes zero to empty flag
// [RL18] Load shifter when idle or after stop
// [RL19] Unused upper written bits are ignored
// [RL20] Parity is xor of data, odd inverts
// [RL21] Ready flag tracks unread receive data
// [RL22] Bit timing advances only on bit tick
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module utrd_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        baud_tick,
   input  wire logic        ext_xfer_clock_pin,
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   output logic             serial_out_en,
   output logic             rx_pin_owned,
   input  wire logic        tx_done_irq_ack,
   output logic             tx_buf_empty_irq,
   output logic             tx_done_irq
);
   utrd_rx_if rxl ();

   logic [7:0]            ctrl_b;
   logic [7:0]            fmt;
   logic [8:0]            tx_buf;
   logic                  tx_buf_full;
   logic                  tx_done_flag;
   logic                  tx_active;
   logic [8:0]            shreg;
   logic                  par_bit;
   logic [3:0]            cnt;
   utrd_pkg::utrd_state_t state;
   logic [8:0]            rx_buf;
   logic                  rx_ready_flag;
   logic [2:0]            xck_sync;
   logic [2:0]            rxd_sync;
   logic                  xck_f;
   logic                  xck_prev;
   logic                  rxd_f;
   logic                  wr_pend;
   logic                  rd_pend;
   logic [7:0]            acc_addr;
   logic                  sync_mode;
   logic                  tx_tick;
   logic                  rx_tick;
   logic [3:0]            nbits;
   logic [8:0]            bit_mask;
   logic                  wr_data;
   logic                  wr_csa;
   logic                  rd_data;
   logic                  frame_end;
   logic                  load_sh;
   logic                  last_data;
   logic [31:0]           rd_mux;

   // Frame format decode
   assign sync_mode = fmt[utrd_pkg::SYNC_POS];
   assign nbits     = (fmt[utrd_pkg::SIZE_POS +: 3] == utrd_pkg::SIZE_NINE) ? utrd_pkg::BITS_NINE
                    : utrd_pkg::BITS_BASE + {2'b00, fmt[utrd_pkg::SIZE_POS +: 2]};
   assign bit_mask  = 9'(~(10'h3ff << nbits));

   // Pin filters: change taken once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         xck_sync <= 3'h0;
         rxd_sync <= 3'h7;
         xck_f    <= 1'b0;
         xck_prev <= 1'b0;
         rxd_f    <= 1'b1;
      end
      else
      begin
         xck_sync <= {xck_sync[1:0], ext_xfer_clock_pin};
         rxd_sync <= {rxd_sync[1:0], serial_in_pin};
         xck_prev <= xck_f;
         if (xck_sync[1] == xck_sync[2])
            xck_f <= xck_sync[2];
         if (rxd_sync[1] == rxd_sync[2])
            rxd_f <= rxd_sync[2];
      end
   end

   // Bit ticks: external clock edges or the baud tick
   assign tx_tick = sync_mode ? (xck_prev & ~xck_f) : baud_tick;   // [RL12] [RL22]
   assign rx_tick = sync_mode ? (xck_f & ~xck_prev) : baud_tick;   // [RL12] [RL22]

   // Receiver hookup
   assign rxl.tick      = rx_tick;
   assign rxl.enable    = ctrl_b[utrd_pkg::RX_EN_POS];
   assign rxl.line      = rxd_f | ~ctrl_b[utrd_pkg::RX_EN_POS];      // [RL11]
   assign rxl.parity_en = fmt[utrd_pkg::PAR_HI_POS];
   assign rxl.nbits     = nbits;

   utrd_rx utrd_rx_i (
      .hclk    (hclk),
      .hresetn (hresetn),
      .rxl     (rxl)
   );

   // Bus access strobes
   assign wr_data   = wr_pend && acc_addr == utrd_pkg::ADDR_DATA;
   assign wr_csa    = wr_pend && acc_addr == utrd_pkg::ADDR_CSA;
   assign rd_data   = rd_pend && acc_addr == utrd_pkg::ADDR_DATA;

   // AHB-Lite slave: zero-wait writes, one wait state on reads
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         acc_addr  <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end
      else
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         if (rd_pend)
         begin
            hrdata    <= rd_mux;
            hreadyout <= 1'b1;
         end
         else if (hsel && hready && htrans[1])
         begin
            acc_addr  <= haddr[7:0];
            wr_pend   <= hwrite;
            rd_pend   <= ~hwrite;
            hreadyout <= hwrite;
         end
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (acc_addr)
         utrd_pkg::ADDR_DATA:
            rd_mux[7:0] = rx_buf[7:0] & bit_mask[7:0];                 // [RL16]
         utrd_pkg::ADDR_CSA:
         begin
            rd_mux[utrd_pkg::RX_READY_POS] = rx_ready_flag;
            rd_mux[utrd_pkg::TX_DONE_POS]  = tx_done_flag;
            rd_mux[utrd_pkg::TX_EMPTY_POS] = ~tx_buf_full;            // [RL2]
         end
         utrd_pkg::ADDR_CSB:
         begin
            rd_mux[7:0]                    = ctrl_b;
            rd_mux[utrd_pkg::RX_NINTH_POS] = rx_buf[8];
         end
         utrd_pkg::ADDR_CSC:
            rd_mux[7:0] = fmt;
         default:
            rd_mux = 32'h0000_0000;
      endcase
   end

   // Control and format registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_b <= utrd_pkg::CSB_RESET;
         fmt    <= utrd_pkg::CSC_RESET;
      end
      else if (wr_pend)
      begin
         if (acc_addr == utrd_pkg::ADDR_CSB)
            ctrl_b <= {hwdata[7:2], 1'b0, hwdata[0]};
         if (acc_addr == utrd_pkg::ADDR_CSC)
            fmt <= {1'b0, hwdata[6:0]};
      end
   end

   // Transmit buffer; ninth bit comes from control register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_buf      <= 9'h000;
         tx_buf_full <= 1'b0;
      end
      else if (wr_data)
      begin
         tx_buf      <= {ctrl_b[utrd_pkg::TX_NINTH_POS], hwdata[7:0]} & bit_mask; // [RL1] [RL19]
         tx_buf_full <= 1'b1;                                          // [RL3]
      end
      else if (load_sh)
         tx_buf_full <= 1'b0;                                          // [RL2]
   end

   // Shifter load points
   assign frame_end = tx_tick && state == utrd_pkg::ST_FINISH;
   assign load_sh   = tx_active && tx_buf_full
                    && (state == utrd_pkg::ST_IDLE || frame_end);      // [RL18]
   assign last_data = cnt == nbits - 4'h1;

   // Transmit sequencer; state names the next bit to send
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state          <= utrd_pkg::ST_IDLE;
         shreg          <= 9'h000;
         par_bit        <= 1'b0;
         cnt            <= 4'h0;
         serial_out_pin <= 1'b1;
      end
      else if (load_sh)
      begin
         shreg   <= tx_buf;
         par_bit <= (^tx_buf) ^ fmt[utrd_pkg::PAR_LO_POS];            // [RL20]
         cnt     <= 4'h0;
         if (frame_end)
         begin
            serial_out_pin <= 1'b0;
            state          <= utrd_pkg::ST_DATA;
         end
         else
            state <= utrd_pkg::ST_START;
      end
      else if (tx_tick)
      begin
         case (state)
            utrd_pkg::ST_IDLE:
               serial_out_pin <= 1'b1;
            utrd_pkg::ST_START:
            begin
               serial_out_pin <= 1'b0;
               state          <= utrd_pkg::ST_DATA;
            end
            utrd_pkg::ST_DATA:
            begin
               serial_out_pin <= shreg[0];
               shreg          <= {1'b0, shreg[8:1]};
               cnt            <= cnt + 4'h1;
               if (last_data)
                  state <= fmt[utrd_pkg::PAR_HI_POS] ? utrd_pkg::ST_PARITY
                                                     : utrd_pkg::ST_STOP;  // [RL8]
            end
            utrd_pkg::ST_PARITY:
            begin
               serial_out_pin <= par_bit;                              // [RL8]
               state          <= utrd_pkg::ST_STOP;
            end
            utrd_pkg::ST_STOP:
            begin
               serial_out_pin <= 1'b1;
               state <= fmt[utrd_pkg::STOP2_POS] ? utrd_pkg::ST_STOP2 : utrd_pkg::ST_FINISH;
            end
            utrd_pkg::ST_STOP2:
            begin
               serial_out_pin <= 1'b1;
               state          <= utrd_pkg::ST_FINISH;
            end
            utrd_pkg::ST_FINISH:
               state <= utrd_pkg::ST_IDLE;
            default:
               state <= utrd_pkg::ST_IDLE;
         endcase
      end
   end

   // Transmitter ownership of the output pin
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_active     <= 1'b0;
         serial_out_en <= 1'b0;
      end
      else
      begin
         if (ctrl_b[utrd_pkg::TX_EN_POS])
            tx_active <= 1'b1;
         else if (state == utrd_pkg::ST_IDLE && !tx_buf_full)
            tx_active <= 1'b0;                                         // [RL9]
         serial_out_en <= tx_active;                                   // [RL10]
      end
   end

   // Transmit-done flag; a set beats a clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tx_done_flag <= 1'b0;
      else if (frame_end && !tx_buf_full)
         tx_done_flag <= 1'b1;                                         // [RL5]
      else if (tx_done_irq_ack || (wr_csa && hwdata[utrd_pkg::TX_DONE_POS]))
         tx_done_flag <= 1'b0;                                         // [RL6]
   end

   // Receive buffer and ready flag; disable clears the ready flag, the buffer keeps its data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_buf        <= 9'h000;
         rx_ready_flag <= 1'b0;
      end
      else if (!ctrl_b[utrd_pkg::RX_EN_POS])
         rx_ready_flag <= 1'b0;
      else if (rxl.done)
      begin
         rx_buf        <= rxl.data;                                    // [RL15]
         rx_ready_flag <= 1'b1;                                        // [RL21]
      end
      else if (rd_data)
         rx_ready_flag <= 1'b0;                                        // [RL21]
   end

   // Interrupt requests and pin ownership, registered
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_buf_empty_irq <= 1'b0;
         tx_done_irq      <= 1'b0;
         rx_pin_owned     <= 1'b0;
      end
      else
      begin
         tx_buf_empty_irq <= ~tx_buf_full & ctrl_b[utrd_pkg::TX_EMPTY_IE_POS];  // [RL4]
         tx_done_irq      <= tx_done_flag & ctrl_b[utrd_pkg::TX_DONE_IE_POS];   // [RL7]
         rx_pin_owned     <= ctrl_b[utrd_pkg::RX_EN_POS];                       // [RL11]
      end
   end

   // Transfer size is always a word on this bus
   logic unused_ok;
   assign unused_ok = ^{hsize, hwdata[31:8]};
endmodule

// ---- tb/utrd_top_properties.sv ----
// Port-level assertions on the serial data path.
// Assumes binding to utrd_top with the baud tick on hclk.
`timescale 1ns/1ps
module utrd_top_properties (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        baud_tick,
   input wire logic        serial_out_pin,
   input wire logic        serial_out_en,
   input wire logic        rx_pin_owned,
   input wire logic        tx_done_irq_ack,
   input wire logic        tx_done_irq
);
   logic csb_wr;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Control register write seen in its address phase
   assign csb_wr = hsel && hready && hwrite && htrans[1] && (haddr[7:0] == utrd_pkg::ADDR_CSB);

   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not OKAY");
   chk_read_wait: assert property (!hreadyout |=> hreadyout)
      else $error("read wait longer than one cycle");
   chk_bit_on_tick: assert property ($changed(serial_out_pin) |-> $past(baud_tick) || $past(baud_tick, 2))
      else $error("output bit changed away from a tick");
   chk_start_owned: assert property ($fell(serial_out_pin) |-> serial_out_en)
      else $error("start bit while pin not owned");
   chk_release_idle: assert property ($fell(serial_out_en) |-> serial_out_pin && $past(serial_out_pin))
      else $error("pin released before frame end");
   chk_ack_clears: assert property (tx_done_irq_ack |-> ##2 !tx_done_irq)
      else $error("done request not cleared by service");
   chk_done_on_tick: assert property ($rose(tx_done_irq) |-> $past(baud_tick, 2) || $past(baud_tick, 3))
      else $error("done request not at a stop tick");
   chk_rx_own_write: assert property ($changed(rx_pin_owned) |-> $past(csb_wr) || $past(csb_wr, 2) || $past(csb_wr, 3))
      else $error("input pin ownership changed without write");
endmodule

// ---- tb/utrd_node_model.sv ----
// Remote serial node: sends frames and captures transmitted ones.
// Assumes a mid-bit strobe half a bit away from the device tick.
`timescale 1ns/1ps
module utrd_node_model (
   input  wire logic        hclk,
   input  wire logic        mid,
   input  wire logic        serial_out_pin,
   input  wire logic        serial_out_en,
   input  wire logic [3:0]  nb,
   output logic             serial_in_pin,
   output int               n_frames,
   output logic      [11:0] last_frame
);
   logic        busy;
   logic [3:0]  cnt;
   logic [11:0] frame;

   // Idle line is high between frames
   initial
   begin
      serial_in_pin = 1'b1;
      n_frames = 0;
      busy = 1'b0;
      last_frame = 12'h0;
   end

   // Start bit, then nb bits sampled mid-bit
   always @(posedge hclk)
   begin
      if (mid && !busy && serial_out_en && !serial_out_pin)
      begin
         busy <= 1'b1;
         cnt <= 4'h0;
         frame <= 12'h0;
      end
      else if (mid && busy)
      begin
         frame[cnt] <= serial_out_pin;
         cnt <= cnt + 4'h1;
         if (cnt == nb - 4'h1)
         begin
            busy <= 1'b0;
            last_frame <= frame | ({11'h0, serial_out_pin} << cnt);
            n_frames <= n_frames + 1;
         end
      end
   end

   // Drive bits LSB first, one per mid-bit strobe
   task automatic send(input logic [19:0] b, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge hclk iff mid);
         serial_in_pin <= b[i];
      end
      @(posedge hclk iff mid);
   endtask
endmodule

// ---- tb/usart_tx_rx_datapath_tb.sv ----
// Self-checking bench for the serial data path.
// Assumes the node model on the serial pins, tick every 16 cycles.
`timescale 1ns/1ps
module usart_tx_rx_datapath_tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        baud_tick;
   logic        mid;
   logic [3:0]  div;
   logic        xck;
   logic        xck_on;
   logic        serial_in_pin;
   logic        serial_out_pin;
   logic        serial_out_en;
   logic        rx_pin_owned;
   logic        tx_done_irq_ack;
   logic        tx_buf_empty_irq;
   logic        tx_done_irq;
   logic [3:0]  nb;
   logic [11:0] last_frame;
   logic [31:0] rd;
   int          n_frames;
   int          num_errors;
   int          n_compared;

   always #50 hclk = ~hclk;

   // Bit tick, external transfer clock and the node's mid-bit strobe
   always @(posedge hclk)
   begin
      div <= div + 4'h1;
      baud_tick <= !xck_on && (div == 4'he);
      xck <= xck_on && (div > 4'ha);
      mid <= (div == 4'h6);
   end

   utrd_top utrd_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .baud_tick(baud_tick), .ext_xfer_clock_pin(xck),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_en(serial_out_en),
      .rx_pin_owned(rx_pin_owned), .tx_done_irq_ack(tx_done_irq_ack),
      .tx_buf_empty_irq(tx_buf_empty_irq), .tx_done_irq(tx_done_irq));

   utrd_node_model utrd_node_model_i (.hclk(hclk), .mid(mid), .serial_out_pin(serial_out_pin),
      .serial_out_en(serial_out_en), .nb(nb), .serial_in_pin(serial_in_pin), .n_frames(n_frames),
      .last_frame(last_frame));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One AHB-Lite single transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(n, rd & m, e);
   endtask

   // Wait for the k-th captured frame, then past its final tick
   task automatic frame(input int k, input logic [11:0] e);
      int t = 0;
      while (n_frames < k && t < 3000)
      begin
         @(posedge hclk);
         t++;
      end
      check("frame_count", n_frames, k);
      check("frame", {20'h0, last_frame}, {20'h0, e});
      repeat (24) @(posedge hclk);
   endtask

   task automatic report_and_stop;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      tx_done_irq_ack = 1'b0;
      div = 4'h0;
      baud_tick = 1'b0;
      mid = 1'b0;
      xck_on = 1'b0;
      nb = 4'ha;
      num_errors = 0;
      n_compared = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("csa", 8'h04, 32'hff, 32'h20);
      rchk("csb", 8'h08, 32'hff, 32'h00);
      rchk("fmt", 8'h0c, 32'hff, 32'h06);
      rchk("unmapped", 8'h10, 32'hffffffff, 32'h0);
      // Two back-to-back even-parity bytes
      bus(1'b1, 8'h0c, 32'h23);
      bus(1'b1, 8'h08, 32'h68);
      repeat (3) @(posedge hclk);
      check("empty_irq", {31'h0, tx_buf_empty_irq}, 32'h1);
      bus(1'b1, 8'h00, 32'ha5);
      bus(1'b1, 8'h00, 32'h3c);
      rchk("csa_full", 8'h04, 32'h60, 32'h00);
      check("empty_irq_off", {31'h0, tx_buf_empty_irq}, 32'h0);
      frame(1, {2'h0, 1'b1, ^8'ha5, 8'ha5});
      frame(2, {2'h0, 1'b1, ^8'h3c, 8'h3c});
      rchk("csa_done", 8'h04, 32'h60, 32'h60);
      check("done_irq", {31'h0, tx_done_irq}, 32'h1);
      tx_done_irq_ack <= 1'b1;
      @(posedge hclk);
      tx_done_irq_ack <= 1'b0;
      repeat (3) @(posedge hclk);
      rchk("csa_ack", 8'h04, 32'h60, 32'h20);
      // Five-bit odd parity, upper written bits dropped
      bus(1'b1, 8'h0c, 32'h30);
      nb <= 4'h7;
      bus(1'b1, 8'h00, 32'hff);
      frame(3, {5'h0, 1'b1, ~^5'h1f, 5'h1f});
      bus(1'b1, 8'h04, 32'h40);
      rchk("csa_w1c", 8'h04, 32'h60, 32'h20);
      // Nine-bit character, then disable during a frame
      bus(1'b1, 8'h0c, 32'h07);
      bus(1'b1, 8'h08, 32'h09);
      nb <= 4'ha;
      bus(1'b1, 8'h00, 32'h55);
      frame(4, {2'h0, 1'b1, 1'b1, 8'h55});
      bus(1'b1, 8'h00, 32'h81);
      bus(1'b1, 8'h08, 32'h00);
      check("still_owned", {31'h0, serial_out_en}, 32'h1);
      frame(5, {2'h0, 1'b1, 1'b1, 8'h81});
      check("released", {31'h0, serial_out_en}, 32'h0);
      // Receive: two stops set, frames sent with one stop
      bus(1'b1, 8'h0c, 32'h0b);
      bus(1'b1, 8'h08, 32'h10);
      repeat (3) @(posedge hclk);
      check("rx_owned", {31'h0, rx_pin_owned}, 32'h1);
      fork
         utrd_node_model_i.send({1'b1, 8'h5a, 2'b01, 8'hc3, 1'b0}, 20);
         begin
            repeat (200) @(posedge hclk);
            rchk("rx_ready", 8'h04, 32'h80, 32'h80);
            rchk("rx_a", 8'h00, 32'hffffffff, 32'hc3);
         end
      join
      repeat (30) @(posedge hclk);
      rchk("rx_b", 8'h00, 32'hffffffff, 32'h5a);
      bus(1'b1, 8'h0c, 32'h00);
      utrd_node_model_i.send({13'h1fff, 1'b1, 5'h15, 1'b0}, 7);
      repeat (30) @(posedge hclk);
      rchk("rx_5", 8'h00, 32'hffffffff, 32'h15);
      rchk("rx_empty", 8'h04, 32'h80, 32'h00);
      // Synchronous receive: external clock only, baud tick held off
      bus(1'b1, 8'h0c, 32'h43);
      xck_on <= 1'b1;
      utrd_node_model_i.send({1'b1, 8'h96, 1'b0}, 10);
      repeat (30) @(posedge hclk);
      rchk("rx_sync", 8'h00, 32'hffffffff, 32'h96);
      report_and_stop();
   end

   // Watchdog against a hung wait
   initial
   begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      report_and_stop();
   end
endmodule

bind utrd_top utrd_top_properties utrd_top_properties_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .baud_tick, .serial_out_pin, .serial_out_en, .rx_pin_owned,
   .tx_done_irq_ack, .tx_done_irq);
